// [src/svdc_pkg.sv]
// Package of the supply voltage detect control block: register map, fields, reset values.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package svdc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_THRESHOLD = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h0C;
  localparam logic [7:0] OFF_CLEAR     = 8'h10;
  localparam logic [7:0] OFF_PRIORITY  = 8'h14;
  localparam logic [7:0] OFF_MOD_DIS   = 8'h18;
  localparam logic [7:0] OFF_POWER     = 8'h1C;

  // Control register field positions
  localparam int CTL_EN_BIT   = 7;
  localparam int CTL_OUT_BIT  = 5;
  localparam int CTL_RDY_BIT  = 4;
  localparam int CTL_RISE_BIT = 1;
  localparam int CTL_FALL_BIT = 0;

  // Event flag / enable / priority bit position
  localparam int EVT_BIT      = 7;
  // Module disable bit position
  localparam int MOD_DIS_BIT  = 5;

  // Power mode register field positions
  localparam int PWR_SLEEP_BIT  = 0;
  localparam int PWR_FREEZE_BIT = 1;
  localparam int PWR_GIE_BIT    = 2;

  localparam logic [3:0] THR_RESERVED = 4'hF;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : svdc_pkg

// [src/svdc_bus_if.sv]
// Interface carrying decoded register accesses from the bus slave to the core.
// Assumes both ends share i_core_clk.
`timescale 1ns/1ps
interface svdc_bus_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport core  (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : svdc_bus_if

// [src/svdc_ahb_slave.sv]
// AHB-Lite slave turning single word transfers into register strobes.
// Assumes single NONSEQ word transfers; the top adds one wait state to every read.
`timescale 1ns/1ps
module svdc_ahb_slave (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic [31:0]      o_hrdata,
  svdc_bus_if.slave        bus
);
  typedef struct packed {
    logic       wr_pend;
    logic       rd_pend;
    logic [7:0] addr;
  } svdc_slv_t;

  svdc_slv_t s_r;
  svdc_slv_t s_nxt;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.wr_pend = 1'b0;
    s_nxt.rd_pend = 1'b0;
    if (i_hsel && i_hready && i_htrans == svdc_pkg::HTRANS_NONSEQ) begin
      s_nxt.wr_pend = i_hwrite;
      s_nxt.rd_pend = !i_hwrite;
      s_nxt.addr    = i_haddr[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.wr_stb = s_r.wr_pend;
  assign bus.rd_stb = s_r.rd_pend;
  assign bus.addr   = s_r.addr;
  assign bus.wdata  = i_hwdata[7:0];
  assign o_hrdata   = {24'h000000, bus.rdata};
endmodule : svdc_ahb_slave

// [src/svdc_top.sv]
// Control and event logic of the supply voltage detector, with AHB-Lite registers.
// Assumes comparator and reference-ready inputs already synchronous to i_core_clk.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// Behaviour
// - No event flag before reference reports ready after enabling.
// - Readiness taken from reference input, never from a cycle count.
// - In sleep a crossing sets the flag and requests wake-up.
// - After wake-up vector to interrupt only when global interrupts enabled.
// - Idle and doze leave the detector fully active.
// - Freeze suppresses new events and interrupt requests.
// - Freeze holds the reference-ready status bit.
// - Register reads and writes still work during freeze.
// - Reset returns all registers to reset values, detector off.
// - Threshold register holds 4-bit code; code 1111 reserved.
// - Threshold upper four bits read as zero.
// - Rise, fall or both enables select flagged crossing direction.
// - Toggling detector enable produces no spurious event.
// - Interrupt only when enabled and reference ready.
module svdc_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_cmp_above,
  input  wire logic        i_ref_ready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_det_power_en,
  output logic [3:0]       o_threshold_code,
  output logic             o_irq,
  output logic             o_wake_req,
  output logic             o_vector_req
);
  typedef struct packed {
    logic       det_en;
    logic       rise_en;
    logic       fall_en;
    logic [3:0] thr_code;
    logic       evt_flag;
    logic       evt_irq_en;
    logic       evt_prio;
    logic       mod_dis;
    logic       sleep;
    logic       freeze;
    logic       global_irq_enable;
    logic       cmp_q;
    logic       rdy_q;
    logic       cmp_prev;
    logic       armed;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    logic       vector;
    logic       hready;
  } svdc_state_t;

  // Bus ready idles high out of reset
  localparam svdc_state_t ST_RESET = '{hready: 1'b1, default: '0};

  svdc_state_t st_r;
  svdc_state_t st_nxt;
  svdc_bus_if  bus ();

  logic unused_hsize;
  assign unused_hsize = ^i_hsize;

  svdc_ahb_slave u_slave (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_hsel     (i_hsel),
    .i_haddr    (i_haddr),
    .i_htrans   (i_htrans),
    .i_hwrite   (i_hwrite),
    .i_hready   (i_hready),
    .i_hwdata   (i_hwdata),
    .o_hrdata   (o_hrdata),
    .bus        (bus.slave)
  );

  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = bus.wr_stb && bus.addr == off;
  endfunction : wr_hit

  logic active;
  logic rise_edge;
  logic fall_edge;
  logic crossing;

  always_comb begin
    // Detector is live only when powered and not module-disabled; reference ready gates events separately
    active    = st_r.det_en && !st_r.mod_dis;
    rise_edge = st_r.cmp_q && !st_r.cmp_prev;
    fall_edge = !st_r.cmp_q && st_r.cmp_prev;
    crossing  = (st_r.rise_en && rise_edge) || (st_r.fall_en && fall_edge);

    st_nxt = st_r;

    st_nxt.cmp_q = i_cmp_above;
    // ready held in freeze; taken from the reference
    if (!st_r.freeze) begin
      st_nxt.rdy_q = i_ref_ready && active;
    end
    // comparison restarts only once ready, no edge at enable
    st_nxt.cmp_prev = st_r.cmp_q;
    st_nxt.armed    = active && st_r.rdy_q;

    if (st_r.armed && active && st_r.rdy_q && !st_r.freeze && crossing) begin
      st_nxt.evt_flag = 1'b1;
    end else if (wr_hit(svdc_pkg::OFF_CLEAR) && bus.wdata[svdc_pkg::EVT_BIT]) begin
      st_nxt.evt_flag = 1'b0;
    end

    if (wr_hit(svdc_pkg::OFF_CONTROL)) begin
      st_nxt.det_en  = bus.wdata[svdc_pkg::CTL_EN_BIT];
      st_nxt.rise_en = bus.wdata[svdc_pkg::CTL_RISE_BIT];
      st_nxt.fall_en = bus.wdata[svdc_pkg::CTL_FALL_BIT];
    end
    // 4-bit code, reserved value stored as written
    if (wr_hit(svdc_pkg::OFF_THRESHOLD)) begin
      st_nxt.thr_code = bus.wdata[3:0];
    end
    if (wr_hit(svdc_pkg::OFF_IRQ_EN)) begin
      st_nxt.evt_irq_en = bus.wdata[svdc_pkg::EVT_BIT];
    end
    if (wr_hit(svdc_pkg::OFF_PRIORITY)) begin
      st_nxt.evt_prio = bus.wdata[svdc_pkg::EVT_BIT];
    end
    if (wr_hit(svdc_pkg::OFF_MOD_DIS)) begin
      st_nxt.mod_dis = bus.wdata[svdc_pkg::MOD_DIS_BIT];
    end
    if (wr_hit(svdc_pkg::OFF_POWER)) begin
      st_nxt.sleep  = bus.wdata[svdc_pkg::PWR_SLEEP_BIT];
      st_nxt.freeze = bus.wdata[svdc_pkg::PWR_FREEZE_BIT];
      st_nxt.global_irq_enable    = bus.wdata[svdc_pkg::PWR_GIE_BIT];
    end

    // one wait state per read
    // Read data is loaded in the wait cycle, after any earlier write has landed
    st_nxt.hready = !(i_hsel && i_hready && i_htrans == svdc_pkg::HTRANS_NONSEQ && !i_hwrite);

    // Read mux, loaded every cycle from the held address of the last read or write
    st_nxt.rdata = 8'h00;
    case (bus.addr)
      svdc_pkg::OFF_CONTROL: begin
        st_nxt.rdata[svdc_pkg::CTL_EN_BIT]   = st_r.det_en;
        st_nxt.rdata[svdc_pkg::CTL_OUT_BIT]  = st_r.cmp_q;
        st_nxt.rdata[svdc_pkg::CTL_RDY_BIT]  = st_r.rdy_q;
        st_nxt.rdata[svdc_pkg::CTL_RISE_BIT] = st_r.rise_en;
        st_nxt.rdata[svdc_pkg::CTL_FALL_BIT] = st_r.fall_en;
      end
      svdc_pkg::OFF_THRESHOLD: st_nxt.rdata = {4'h0, st_r.thr_code};
      svdc_pkg::OFF_STATUS:    st_nxt.rdata[svdc_pkg::EVT_BIT] = st_r.evt_flag;
      svdc_pkg::OFF_IRQ_EN:    st_nxt.rdata[svdc_pkg::EVT_BIT] = st_r.evt_irq_en;
      svdc_pkg::OFF_PRIORITY:  st_nxt.rdata[svdc_pkg::EVT_BIT] = st_r.evt_prio;
      svdc_pkg::OFF_MOD_DIS:   st_nxt.rdata[svdc_pkg::MOD_DIS_BIT] = st_r.mod_dis;
      svdc_pkg::OFF_POWER: begin
        st_nxt.rdata[svdc_pkg::PWR_SLEEP_BIT]  = st_r.sleep;
        st_nxt.rdata[svdc_pkg::PWR_FREEZE_BIT] = st_r.freeze;
        st_nxt.rdata[svdc_pkg::PWR_GIE_BIT]    = st_r.global_irq_enable;
      end
      default: st_nxt.rdata = 8'h00;
    endcase

    // freeze masks the request; flag already gated by ready
    st_nxt.irq    = st_r.evt_flag && st_r.evt_irq_en && !st_r.freeze;
    // wake from sleep on the flag
    st_nxt.wake   = st_r.sleep && st_r.evt_flag && st_r.evt_irq_en && !st_r.freeze;
    // vector only with global interrupts on
    st_nxt.vector = st_r.evt_flag && st_r.evt_irq_en && st_r.global_irq_enable && !st_r.freeze;
  end

  always_ff @(posedge i_core_clk) begin
    // everything to reset value, detector off
    if (!i_resetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.rdata        = st_r.rdata;
  assign o_hreadyout      = st_r.hready;
  assign o_hresp          = 1'b0;
  assign o_det_power_en   = st_r.det_en;
  assign o_threshold_code = st_r.thr_code;
  assign o_irq            = st_r.irq;
  assign o_wake_req       = st_r.wake;
  assign o_vector_req     = st_r.vector;
endmodule : svdc_top

// [test/svdc_properties.sv]
// Port-level checker of svdc_top.
// Assumes i_hready is fed from o_hreadyout and i_hsel marks this slave.
`timescale 1ns/1ps
module svdc_properties (
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] i_hwdata,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_det_power_en,
  input wire logic [3:0]  o_threshold_code,
  input wire logic        o_irq,
  input wire logic        o_wake_req,
  input wire logic        o_vector_req
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic       ap_r;
  logic [7:0] wa_r;
  logic [2:0] pwr_r;
  // Mirror of write data phases and of the power mode register
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ap_r  <= 1'b0;
      wa_r  <= 8'h00;
      pwr_r <= 3'h0;
    end else begin
      if (i_hready) begin
        ap_r <= i_hsel && i_hwrite && i_htrans == svdc_pkg::HTRANS_NONSEQ;
        wa_r <= i_haddr[7:0];
      end
      if (ap_r && wa_r == svdc_pkg::OFF_POWER) begin
        pwr_r <= i_hwdata[2:0];
      end
    end
  end
  sequence s_thr_wr;
    ap_r && wa_r == svdc_pkg::OFF_THRESHOLD && i_hwdata[3:0] != svdc_pkg::THR_RESERVED;
  endsequence
  sequence s_rd_acc;
    i_hsel && i_hready && i_htrans == svdc_pkg::HTRANS_NONSEQ && !i_hwrite;
  endsequence
  sequence s_one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  property p_ok; !o_hresp; endproperty
  property p_wait; s_rd_acc |=> s_one_wait; endproperty
  property p_rst;
    disable iff (1'b0) !i_resetn |=> !(o_irq | o_wake_req | o_vector_req) && o_threshold_code == 4'h0;
  endproperty
  property p_thr; s_thr_wr |=> o_threshold_code == $past(i_hwdata[3:0]); endproperty
  property p_upper; o_hrdata[31:8] == 24'h0; endproperty
  property p_glitch; $rose(o_det_power_en) |=> $stable(o_irq) [*2]; endproperty
  property p_frz; pwr_r[1] && $past(pwr_r[1]) |-> !o_irq; endproperty
  property p_wake; o_wake_req |-> o_irq && $past(pwr_r[0]); endproperty
  property p_vec; o_vector_req |-> o_irq && $past(pwr_r[2]); endproperty
  a_ok: assert property (p_ok) else $error("bus answer not OKAY");
  a_wait: assert property (p_wait) else $error("read wait state not one cycle");
  a_rst: assert property (p_rst) else $error("output active after reset");
  a_thr: assert property (p_thr) else $error("threshold code not stored");
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  a_glitch: assert property (p_glitch) else $error("enable changed interrupt");
  a_frz: assert property (p_frz) else $error("interrupt during freeze");
  a_wake: assert property (p_wake) else $error("wake without sleep event");
  a_vec: assert property (p_vec) else $error("vector without global enable");
endmodule : svdc_properties

// [test/svdc_top_tb.sv]
// Self-checking bench of svdc_top: registers over AHB-Lite, events, power modes.
// Assumes writes without wait states and one wait state on every read.
`timescale 1ns/1ps
module svdc_top_tb;
  logic        i_core_clk  = 1'b0;
  logic        i_resetn    = 1'b0;
  logic [31:0] i_haddr     = 32'h0;
  logic [1:0]  i_htrans    = 2'h0;
  logic        i_hwrite    = 1'b0;
  logic [31:0] i_hwdata    = 32'h0;
  logic        i_cmp_above = 1'b0;
  logic        i_ref_ready = 1'b0;
  logic [31:0] o_hrdata;
  logic        o_hreadyout, o_hresp, o_det_power_en, o_irq, o_wake_req, o_vector_req;
  logic [3:0]  o_threshold_code;
  logic [31:0] lfsr_r = 32'h7992E23F;
  logic [31:0] rd_v;
  logic [7:0]  v;
  logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h40};
  int          bad_count = 0;
  int          samples_checked = 0;
  always #10 i_core_clk = ~i_core_clk;
  svdc_top u_svdc_top (.i_core_clk, .i_resetn, .i_hsel(1'b1), .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize(3'h2), .i_hready(o_hreadyout), .i_hwdata, .i_cmp_above, .i_ref_ready, .o_hrdata,
    .o_hreadyout, .o_hresp, .o_det_power_en, .o_threshold_code, .o_irq, .o_wake_req,
    .o_vector_req);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] stat(input logic f);
    return {24'h0, f, 7'h0};
  endfunction : stat
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_haddr  <= {24'h0, a};
    i_htrans <= svdc_pkg::HTRANS_NONSEQ;
    i_hwrite <= 1'b1;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= {24'h0, d};
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    i_haddr  <= {24'h0, a};
    i_htrans <= svdc_pkg::HTRANS_NONSEQ;
    i_hwrite <= 1'b0;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    chk(o_hrdata, exp);
  endtask : rc
  // Detector off, flag cleared, then enable and make one comparator change
  task automatic ev(input logic [7:0] ctl, input logic c0, input logic c1);
    wr(svdc_pkg::OFF_CONTROL, 8'h00);
    wr(svdc_pkg::OFF_CLEAR, 8'h80);
    i_cmp_above <= c0;
    wr(svdc_pkg::OFF_CONTROL, ctl);
    tick(4);
    i_cmp_above <= c1;
    tick(5);
  endtask : ev
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    foreach (offs[i]) rc(offs[i], 32'h0);
    wr(8'h40, 8'hFF);
    wr(svdc_pkg::OFF_CONTROL, 8'h30);
    wr(svdc_pkg::OFF_STATUS, 8'h80);
    foreach (offs[i]) rc(offs[i], 32'h0);
    for (int i = 0; i < 10; i++) begin
      lfsr_r = lfsr(lfsr_r);
      v = (i == 0) ? 8'hF0 : (i == 1) ? 8'h7E : lfsr_r[7:0];
      if (v[3:0] == svdc_pkg::THR_RESERVED) v[3:0] = 4'h3;
      wr(svdc_pkg::OFF_THRESHOLD, v);
      rc(svdc_pkg::OFF_THRESHOLD, {28'h0, v[3:0]});
      chk({28'h0, o_threshold_code}, {28'h0, v[3:0]});
    end
    i_ref_ready <= 1'b1;
    wr(svdc_pkg::OFF_IRQ_EN, 8'h80);
    for (int m = 1; m < 4; m++) begin
      for (int u = 0; u < 2; u++) begin
        ev(8'h80 | 8'(m), ~u[0], u[0]);
        rc(svdc_pkg::OFF_STATUS, stat(u[0] ? m[1] : m[0]));
        chk({31'h0, o_irq}, {31'h0, u[0] ? m[1] : m[0]});
      end
    end
    ev(8'h83, 1'b1, 1'b1);
    rc(svdc_pkg::OFF_STATUS, stat(1'b0));
    i_ref_ready <= 1'b0;
    ev(8'h83, 1'b0, 1'b1);
    rc(svdc_pkg::OFF_STATUS, stat(1'b0));
    rc(svdc_pkg::OFF_CONTROL, 32'hA3);
    i_ref_ready <= 1'b1;
    ev(8'h83, 1'b1, 1'b0);
    wr(svdc_pkg::OFF_POWER, 8'h01);
    tick(2);
    chk({30'h0, o_wake_req, o_vector_req}, 32'h2);
    wr(svdc_pkg::OFF_POWER, 8'h05);
    tick(2);
    chk({30'h0, o_wake_req, o_vector_req}, 32'h3);
    wr(svdc_pkg::OFF_POWER, 8'h02);
    wr(svdc_pkg::OFF_CLEAR, 8'h80);
    i_ref_ready <= 1'b0;
    i_cmp_above <= 1'b1;
    tick(5);
    rc(svdc_pkg::OFF_STATUS, stat(1'b0));
    rc(svdc_pkg::OFF_CONTROL, 32'hB3);
    wr(svdc_pkg::OFF_THRESHOLD, 8'h05);
    rc(svdc_pkg::OFF_THRESHOLD, 32'h5);
    i_resetn <= 1'b0;
    tick(2);
    i_resetn <= 1'b1;
    rc(svdc_pkg::OFF_CONTROL, 32'h20);
    chk({28'h0, o_threshold_code}, 32'h0);
    chk({31'h0, o_det_power_en}, 32'h0);
    conclude();
  end
endmodule : svdc_top_tb
bind svdc_top svdc_properties u_svdc_properties (.i_core_clk, .i_resetn, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hready, .i_hwdata, .o_hrdata, .o_hreadyout, .o_hresp,
  .o_det_power_en, .o_threshold_code, .o_irq, .o_wake_req, .o_vector_req);
